/* verilog/ieq_queue.sv */
// instrument error queue: fifo of error code and message
// assumes synchronous requests, one clock, async high reset
`include "ieq_defines.svh"
`default_nettype none
module ieq_queue #(
	parameter int DEPTH  = `IEQ_DEPTH,
	parameter int CODE_W = `IEQ_CODE_W,
	parameter int MSG_W  = `IEQ_MSG_W
) (
	input  wire logic              core_clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              err_push_in,
	input  wire logic              err_from_panel_in,
	input  wire logic [CODE_W-1:0] err_code_in,
	input  wire logic [MSG_W-1:0]  err_msg_in,
	input  wire logic              query_in,
	input  wire logic              clear_in,
	output logic                   resp_valid_out,
	output logic      [CODE_W-1:0] resp_code_out,
	output logic      [MSG_W-1:0]  resp_msg_out,
	output logic      [5:0]        count_out,
	output logic                   overflow_out
);
	localparam int AW = 5;
	localparam int W  = CODE_W + MSG_W;

	logic [AW-1:0] rd_ptr_q, wr_ptr_q;
	logic [5:0]    count_q;
	logic          ovfl_q;
	logic          pop_empty_q;
	logic          resp_pend_q;
	logic [W-1:0]  rd_data;
	logic          full, empty, src_push, do_push, do_pop, do_mark;
	logic [AW-1:0] last_ptr;
	ieq_pkg::ieq_op_e op;

	assign full     = (count_q == 6'(DEPTH));
	assign empty    = (count_q == 6'h00);
	assign src_push = err_push_in && !err_from_panel_in;
	assign do_pop   = query_in && !empty && !clear_in;
	// marker lands once per overflow; after it pushes are dropped until a pop or clear
	assign do_mark  = src_push && full && !ovfl_q && !do_pop && !clear_in;
	assign do_push  = src_push && !ovfl_q && !clear_in && (!full || do_pop);
	assign last_ptr = (wr_ptr_q == 5'h00) ? 5'(DEPTH - 1) : wr_ptr_q - 5'h01;
	assign op       = ieq_pkg::ieq_op_e'({do_pop, do_push});

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		nxt = (p == 5'(DEPTH - 1)) ? 5'h00 : p + 5'h01;
	endfunction : nxt

	ieq_mem #(.DEPTH(DEPTH), .WIDTH(W), .AW(AW)) u_mem (
		.core_clk_in (core_clk_in),
		.wr_en_in    (do_push || do_mark),
		.wr_addr_in  (do_mark ? last_ptr : wr_ptr_q),
		.wr_data_in  (do_mark ? {`IEQ_CODE_OVFL, `IEQ_MSG_OVFL} : {err_code_in, err_msg_in}),
		.rd_addr_in  (rd_ptr_q),
		.rd_data_out (rd_data)
	);

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_ptr_q <= 5'h00;
			wr_ptr_q <= 5'h00;
			count_q  <= 6'h00;
		end else if (clear_in) begin
			rd_ptr_q <= 5'h00;
			wr_ptr_q <= 5'h00;
			count_q  <= 6'h00;
		end else begin
			unique case (op)
				ieq_pkg::IEQ_OP_IDLE: begin
				end
				ieq_pkg::IEQ_OP_PUSH: begin
					wr_ptr_q <= nxt(wr_ptr_q);
					count_q  <= count_q + 6'h01;
				end
				ieq_pkg::IEQ_OP_POP: begin
					rd_ptr_q <= nxt(rd_ptr_q);
					count_q  <= count_q - 6'h01;
				end
				ieq_pkg::IEQ_OP_BOTH: begin
					wr_ptr_q <= nxt(wr_ptr_q);
					rd_ptr_q <= nxt(rd_ptr_q);
				end
			endcase
		end
	end

	// overflow flag: a pop in the same cycle blocks the set; a pop or clear resets it
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ovfl_q <= 1'b0;
		end else if (do_mark) begin
			ovfl_q <= 1'b1;
		end else if (clear_in || do_pop) begin
			ovfl_q <= 1'b0;
		end
	end

	// valid one cycle after the query, data a cycle later from the registered read
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			resp_pend_q <= 1'b0;
			pop_empty_q <= 1'b0;
		end else begin
			resp_pend_q <= query_in;
			pop_empty_q <= query_in && (empty || clear_in);
		end
	end

	assign resp_valid_out = resp_pend_q;

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			resp_code_out <= `IEQ_CODE_NONE;
			resp_msg_out  <= `IEQ_MSG_NONE;
		end else if (resp_pend_q) begin
			if (pop_empty_q) begin
				resp_code_out <= `IEQ_CODE_NONE;
				resp_msg_out  <= `IEQ_MSG_NONE;
			end else begin
				resp_code_out <= rd_data[W-1:MSG_W];
				resp_msg_out  <= rd_data[MSG_W-1:0];
			end
		end
	end

	assign count_out    = count_q;
	assign overflow_out = ovfl_q;

	sequence s_fill_push;
		src_push && full && !ovfl_q && !query_in && !clear_in;
	endsequence

	AST_COUNT_MAX: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) count_q <= 6'(DEPTH))
		else $error("count above thirty");
	AST_EMPTY_QUERY: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(query_in && empty && !clear_in && !do_push) |=> $stable(count_q) ##1 (resp_code_out == `IEQ_CODE_NONE))
		else $error("empty query not answered with zero");
	AST_CLEAR_ALL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		clear_in |=> (count_q == 6'h00) && !ovfl_q)
		else $error("clear did not empty queue");
	AST_OVFL_MARK: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		s_fill_push |=> ovfl_q && (count_q == 6'(DEPTH)))
		else $error("overflow marker not placed");
	AST_REFUSE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(ovfl_q && !query_in && !clear_in) |=> $stable(wr_ptr_q) && $stable(count_q))
		else $error("push accepted after overflow");
	AST_PANEL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(err_push_in && err_from_panel_in && !query_in && !clear_in) |=> $stable(count_q))
		else $error("panel error queued");
	AST_BOTH: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(do_push && do_pop) |=> $stable(count_q))
		else $error("push and pop changed count");
	AST_POP_DEC: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(do_pop && !do_push) |=> (count_q == $past(count_q) - 6'h01))
		else $error("query did not remove one entry");
	AST_PUSH_INC: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(do_push && !do_pop) |=> (count_q == $past(count_q) + 6'h01))
		else $error("error not pushed");
	AST_RESET: assert property (@(posedge core_clk_in)
		$fell(sys_rst_in) |-> (count_q == 6'h00) && (rd_ptr_q == wr_ptr_q) && !ovfl_q)
		else $error("queue not empty after reset");

	// answer path: valid the cycle after a query, data the cycle after that
	sequence s_empty_query;
		query_in && (empty || clear_in) && !do_push;
	endsequence

	sequence s_zero_answer;
		resp_valid_out ##1 ((resp_code_out == `IEQ_CODE_NONE) && (resp_msg_out == `IEQ_MSG_NONE));
	endsequence

	sequence s_mark_push;
		do_mark;
	endsequence

	AST_ZERO_ANSWER: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		s_empty_query |=> s_zero_answer)
		else $error("empty or cleared query not answered with zero");
	AST_VALID_NEXT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		query_in |=> resp_valid_out)
		else $error("query not answered next cycle");
	AST_VALID_QUIET: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		!query_in |=> !resp_valid_out)
		else $error("answer without a query");

	// pointer sanity: a stray pointer would read a slot past the storage
	AST_PTR_RANGE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(rd_ptr_q < 5'(DEPTH)) && (wr_ptr_q < 5'(DEPTH)))
		else $error("pointer outside storage");
	AST_PTR_EQ: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(empty || full) |-> (rd_ptr_q == wr_ptr_q))
		else $error("pointers disagree with count");
	AST_CLEAR_PTRS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		clear_in |=> (rd_ptr_q == 5'h00) && (wr_ptr_q == 5'h00))
		else $error("clear left pointers apart");

	// marker replaces in place, so neither pointer may move with it
	AST_MARK_HOLD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		s_mark_push |=> $stable(wr_ptr_q) && $stable(rd_ptr_q) && ovfl_q)
		else $error("marker moved a pointer");
	AST_OVFL_FULL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		ovfl_q |-> full)
		else $error("overflow while not full");
	AST_PANEL_PTR: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(err_push_in && err_from_panel_in && !clear_in) |=> $stable(wr_ptr_q))
		else $error("panel error moved write pointer");
	AST_POP_EMPTY: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(query_in && empty && !do_push) |=> (count_q == 6'h00))
		else $error("empty query changed count");
endmodule : ieq_queue
`default_nettype wire

/* verilog/ieq_defines.svh */
// constants for the instrument error queue
// assumes inclusion by bare name from the queue sources
`ifndef IEQ_DEFINES_SVH
`define IEQ_DEFINES_SVH
`define IEQ_DEPTH        30
`define IEQ_CODE_W       16
`define IEQ_MSG_W        8
`define IEQ_CODE_NONE    16'h0000
`define IEQ_MSG_NONE     8'h00
`define IEQ_CODE_OVFL    16'hfea2
`define IEQ_MSG_OVFL     8'h01
`endif

/* verilog/ieq_pkg.sv */
// types shared by the error queue sources
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ieq_pkg;
	typedef enum logic [1:0] {
		IEQ_OP_IDLE,
		IEQ_OP_PUSH,
		IEQ_OP_POP,
		IEQ_OP_BOTH
	} ieq_op_e;
endpackage : ieq_pkg
`default_nettype wire

/* verilog/ieq_mem.sv */
// entry storage for the error queue, registered read data
// assumes one clock; write and read addresses are in range
`default_nettype none
module ieq_mem #(
	parameter int DEPTH = 30,
	parameter int WIDTH = 24,
	parameter int AW    = 5
) (
	input  wire logic             core_clk_in,
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic [AW-1:0]    rd_addr_in,
	output logic      [WIDTH-1:0] rd_data_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge core_clk_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
	end

	// read data from a register, no reset needed on storage
	always_ff @(posedge core_clk_in) begin
		rd_data_out <= mem_q[rd_addr_in];
	end
endmodule : ieq_mem
`default_nettype wire

/* tb/ieq_host.sv */
// host model: sends error queries and clear-status pulses
// assumes the answer contract of the queue, drives at rising edges
`default_nettype none
module ieq_host (
	input  wire logic        clk_in,
	input  wire logic        valid_in,
	input  wire logic [15:0] code_in,
	input  wire logic [7:0]  msg_in,
	output logic             query_out,
	output logic             clear_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		query_out = 1'b0;
		clear_out = 1'b0;
	end
	// one query pulse; valid seen next cycle, data one cycle later
	task automatic ask(output logic ok, output logic [15:0] c, output logic [7:0] m);
		@(posedge clk_in);
		query_out <= 1'b1;
		@(posedge clk_in);
		query_out <= 1'b0;
		#1;
		ok = valid_in;
		@(posedge clk_in);
		#1;
		c = code_in;
		m = msg_in;
	endtask : ask
	task automatic clr();
		@(posedge clk_in);
		clear_out <= 1'b1;
		@(posedge clk_in);
		clear_out <= 1'b0;
		#1;
	endtask : clr
endmodule : ieq_host
`default_nettype wire

/* tb/tb_top.sv */
// testbench for the error queue, host model on the query side
// assumes queue, package and host model are compiled first
`include "ieq_defines.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        push = 1'b0;
	logic        panel = 1'b0;
	logic [15:0] code = 16'h0000;
	logic [7:0]  msg = 8'h00;
	logic        qry, clr, vld, ovf;
	logic [15:0] rcode;
	logic [7:0]  rmsg;
	logic [5:0]  cnt;
	int          n_fail = 0;
	int          cmp_count = 0;
	always #20 clk = ~clk;
	ieq_queue uut (.core_clk_in(clk), .sys_rst_in(rst), .err_push_in(push), .err_from_panel_in(panel),
		.err_code_in(code), .err_msg_in(msg), .query_in(qry), .clear_in(clr), .resp_valid_out(vld),
		.resp_code_out(rcode), .resp_msg_out(rmsg), .count_out(cnt), .overflow_out(ovf));
	ieq_host host (.clk_in(clk), .valid_in(vld), .code_in(rcode), .msg_in(rmsg), .query_out(qry),
		.clear_out(clr));
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// message index follows the low code byte so pairing shows
	task automatic put(logic [15:0] c, logic p);
		@(posedge clk);
		push <= 1'b1;
		panel <= p;
		code <= c;
		msg <= c[7:0];
		@(posedge clk);
		push <= 1'b0;
		#1;
	endtask : put
	task automatic get(logic [15:0] c, logic [7:0] m);
		logic ok;
		logic [15:0] gc;
		logic [7:0] gm;
		host.ask(ok, gc, gm);
		chk("valid", 16'h0001, 16'(ok));
		chk("code", c, gc);
		chk("msg", 16'(m), 16'(gm));
	endtask : get
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task automatic t_order();
		chk("count", 16'h0000, 16'(cnt));
		chk("ovfl", 16'h0000, 16'(ovf));
		get(16'h0000, 8'h00);
		chk("count", 16'h0000, 16'(cnt));
		put(16'h1001, 1'b0);
		put(16'h1002, 1'b0);
		put(16'h0bad, 1'b1);
		put(16'h1003, 1'b0);
		chk("count", 16'h0003, 16'(cnt));
		get(16'h1001, 8'h01);
		get(16'h1002, 8'h02);
		get(16'h1003, 8'h03);
		get(16'h0000, 8'h00);
		$display("test order done");
	endtask : t_order
	task automatic t_both();
		put(16'h0011, 1'b0);
		fork
			get(16'h0011, 8'h11);
			put(16'h0022, 1'b0);
		join
		chk("count", 16'h0001, 16'(cnt));
		get(16'h0022, 8'h22);
		put(16'h0031, 1'b0);
		put(16'h0032, 1'b0);
		host.clr();
		chk("count", 16'h0000, 16'(cnt));
		get(16'h0000, 8'h00);
		$display("test both and clear done");
	endtask : t_both
	task automatic t_full();
		for (int i = 0; i <= `IEQ_DEPTH; i++) put(16'(i + 1), 1'b0);
		chk("count", 16'(`IEQ_DEPTH), 16'(cnt));
		chk("ovfl", 16'h0001, 16'(ovf));
		put(16'h0055, 1'b0);
		chk("count", 16'(`IEQ_DEPTH), 16'(cnt));
		get(16'h0001, 8'h01);
		chk("ovfl", 16'h0000, 16'(ovf));
		put(16'h0077, 1'b0);
		chk("count", 16'(`IEQ_DEPTH), 16'(cnt));
		for (int i = 2; i < `IEQ_DEPTH; i++) get(16'(i), 8'(i));
		get(`IEQ_CODE_OVFL, `IEQ_MSG_OVFL);
		get(16'h0077, 8'h77);
		chk("count", 16'h0000, 16'(cnt));
		$display("test overflow done");
	endtask : t_full
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_order();
		t_both();
		t_full();
		end_sim();
	end
	// a hang is cut short here rather than left to run
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
